// ### tb/od_gain_model.sv
// downstream gain-control logic watching the four flags
// assumes flags come straight from the detector outputs
`timescale 1ns/10ps
module od_gain_model (
  input  wire logic a_up_i,
  input  wire logic a_lo_i,
  input  wire logic b_up_i,
  input  wire logic b_lo_i,
  output logic      upper_any_o,
  output logic      lower_any_o
);
  // --------------------------------
  // same-threshold flags merged
  // --------------------------------
  assign upper_any_o = a_up_i | b_up_i;
  assign lower_any_o = a_lo_i | b_lo_i;
endmodule

// ### tb/od_sva.sv
// port assertions for the overrange detector
// assumes binding to the top module, one clock
`timescale 1ns/10ps
module od_sva (
  input wire logic             clock_i,
  input wire logic             resetn_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire od_pkg::od_word_t wb_dat_o,
  input wire logic             chan_a_upper_flag_o,
  input wire logic             chan_a_lower_flag_o,
  input wire logic             chan_b_upper_flag_o,
  input wire logic             chan_b_lower_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // --------------------------------
  // sequences
  // --------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_hold8(logic f);
    f [*8];
  endsequence
  // --------------------------------
  // properties
  // --------------------------------
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_flags_reset: assert property ($rose(resetn_i) |-> !chan_a_upper_flag_o && !chan_b_upper_flag_o
                                  && !chan_a_lower_flag_o && !chan_b_lower_flag_o)
    else $error("flag high after reset");
  a_au_stretch: assert property ($rose(chan_a_upper_flag_o) |-> s_hold8(chan_a_upper_flag_o))
    else $error("a upper flag too short");
  a_al_stretch: assert property ($rose(chan_a_lower_flag_o) |-> s_hold8(chan_a_lower_flag_o))
    else $error("a lower flag too short");
  a_bu_stretch: assert property ($rose(chan_b_upper_flag_o) |-> s_hold8(chan_b_upper_flag_o))
    else $error("b upper flag too short");
  a_bl_stretch: assert property ($rose(chan_b_lower_flag_o) |-> s_hold8(chan_b_lower_flag_o))
    else $error("b lower flag too short");
endmodule

bind overrange_detector od_sva u_sva (
  .clock_i            (clock_i),
  .resetn_i           (resetn_i),
  .wb_cyc_i           (wb_cyc_i),
  .wb_stb_i           (wb_stb_i),
  .wb_ack_o           (wb_ack_o),
  .wb_dat_o           (wb_dat_o),
  .chan_a_upper_flag_o(chan_a_upper_flag_o),
  .chan_a_lower_flag_o(chan_a_lower_flag_o),
  .chan_b_upper_flag_o(chan_b_upper_flag_o),
  .chan_b_lower_flag_o(chan_b_lower_flag_o)
);

// ### tb/test_overrange_detector.sv
// self-checking bench for the overrange detector
// assumes od_pkg, the design and the gain model compiled first
`timescale 1ns/10ps
module test_overrange_detector;
  import od_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  od_sample_t sa = 8'h00;
  od_sample_t sb = 8'h00;
  logic       cyc = 1'b0;
  logic       stb = 1'b0;
  logic       we = 1'b0;
  od_adr_t    adr = 8'h00;
  od_be_t     sel = 4'h0;
  od_word_t   wdat = 32'h0000_0000;
  od_word_t   q;
  wire logic  ack;
  wire od_word_t rdat;
  wire logic [3:0] fl;
  wire logic  up_any;
  wire logic  lo_any;
  int         miscompares = 0;
  int         samples_checked = 0;

  overrange_detector DUT (
    .clock_i(clock_i), .resetn_i(resetn_i), .sample_a_i(sa), .sample_b_i(sb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .chan_a_upper_flag_o(fl[0]), .chan_a_lower_flag_o(fl[1]),
    .chan_b_upper_flag_o(fl[2]), .chan_b_lower_flag_o(fl[3]));
  od_gain_model u_gain (
    .a_up_i(fl[0]), .a_lo_i(fl[1]), .b_up_i(fl[2]), .b_lo_i(fl[3]),
    .upper_any_o(up_any), .lower_any_o(lo_any));

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input od_word_t seen, input od_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input od_adr_t a, input od_be_t s, input od_word_t d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    while (ack !== 1'b1) @(posedge clock_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic hit(input int lane, input od_sample_t v);
    @(posedge clock_i);
    if (lane == 0) sa <= v;
    else sb <= v;
    @(posedge clock_i);
    sa <= 8'h00;
    sb <= 8'h00;
    @(posedge clock_i);
    #1;
  endtask

  task automatic cnt(output int n);
    n = 0;
    while (fl[0] === 1'b1 && n < 2000) begin
      n++;
      @(posedge clock_i);
      #1;
    end
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    wb(1'b0, 8'h00, 4'h0, 0); check(q, 32'h0);
    wb(1'b0, 8'h04, 4'h0, 0); check(q, 32'h0000_407f);
    wb(1'b0, 8'h20, 4'h0, 0); check(q, 32'h0);
    wb(1'b1, 8'h20, 4'hf, 32'hffff_ffff);
    wb(1'b0, 8'h00, 4'h0, 0); check(q, 32'h0);
    wb(1'b1, 8'h04, 4'h1, 32'h0000_ffaa);
    wb(1'b0, 8'h04, 4'h0, 0); check(q, 32'h0000_40aa);
    $display("test regs done");
  endtask

  task automatic t_mag();
    od_sample_t sm[6] = '{8'h70, 8'h90, 8'h80, 8'h7f, 8'h6f, 8'h91};
    int m;
    wb(1'b1, 8'h04, 4'hf, 32'h0000_7f70);
    wb(1'b1, 8'h00, 4'hf, 32'h1);
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 6; i++) begin
        m = sm[i][7] ? ((sm[i] == 8'h80) ? 127 : 256 - sm[i]) : sm[i];
        hit(l, sm[i]);
        check(fl[l*2], m >= 112);
        check(fl[l*2+1], m >= 127);
        check(fl[2-l*2], 0);
        check(up_any, m >= 112);
        repeat (12) @(posedge clock_i);
      end
    end
    $display("test magnitude done");
  endtask

  task automatic t_stretch();
    int n;
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, 8'h00, 4'hf, (s << 1) | 1);
      hit(0, 8'h80);
      cnt(n);
      check(n, 8 << s);
    end
    wb(1'b1, 8'h00, 4'hf, 32'h1);
    hit(0, 8'h80);
    hit(0, 8'h80);
    cnt(n);
    check(n, 8);
    wb(1'b1, 8'h00, 4'hf, 32'h0);
    hit(0, 8'h80);
    check(fl, 4'h0);
    $display("test stretch done");
  endtask

  task automatic t_status();
    wb(1'b0, 8'h0c, 4'h0, 0); check(q, 32'h0000_000f);
    wb(1'b1, 8'h0c, 4'h1, 32'h0000_000f);
    wb(1'b0, 8'h0c, 4'h0, 0); check(q, 32'h0);
    wb(1'b0, 8'h10, 4'h0, 0); check(q, 32'h0000_7f7f);
    wb(1'b1, 8'h10, 4'h3, 0);
    wb(1'b0, 8'h10, 4'h0, 0); check(q, 32'h0);
    wb(1'b1, 8'h04, 4'hf, 32'h0000_4070);
    wb(1'b1, 8'h00, 4'hf, 32'h0000_000f);
    wb(1'b0, 8'h00, 4'h0, 0); check(q, 32'h0000_000f);
    hit(1, 8'h80);
    hit(0, 8'h50);
    check(fl, 4'he);
    check(up_any, 1);
    check(lo_any, 1);
    wb(1'b0, 8'h08, 4'h0, 0); check(q, 32'h0000_000e);
    wb(1'b0, 8'h0c, 4'h0, 0); check(q, 32'h0000_000e);
    wb(1'b1, 8'h00, 4'hf, 32'h0);
    $display("test status done");
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------
  // clock, reset, sequence, watchdog
  // --------------------------------
  initial begin
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_regs();
    t_mag();
    t_stretch();
    t_status();
    final_report();
  end

  initial begin
    #80000;
    miscompares++;
    final_report();
  end
endmodule

// ### verilog/od_chan_detect.sv
// one channel: magnitude, two threshold compares, two stretch counters
// assumes samples and settings come from logic on the same clock
`timescale 1ns/10ps
`include "od_map.svh"
module od_chan_detect (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  od_chan_if.det    chan
);
  import od_pkg::*;

  // ----------------------------------------------------------------
  // magnitude
  // ----------------------------------------------------------------
  od_sample_t  negated;
  od_mag_t     mag;
  logic [10:0] len;
  logic [10:0] len_m1;
  od_thr_t     thr  [2];
  logic        flag [2];

  always_comb begin
    negated = `OD_RST_SAMPLE - chan.sample;
    if (chan.sample == `OD_MOST_NEG) begin
      mag = `OD_MAG_MAX; // R1
    end else if (chan.sample[7]) begin
      mag = negated[6:0]; // R1
    end else begin
      mag = chan.sample[6:0]; // R1
    end
  end

  assign chan.magnitude = mag;
  assign len            = `OD_STRETCH_BASE << chan.stretch_sel;
  assign len_m1         = len - `OD_COUNT_ONE;
  assign thr[0]         = chan.upper_thr;
  assign thr[1]         = chan.lower_thr;
  assign chan.upper_flag = flag[0];
  assign chan.lower_flag = flag[1];

  // ----------------------------------------------------------------
  // compare and stretch, one per threshold
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_thr
      logic [10:0] count;
      logic [10:0] next_count;
      logic        next_flag;
      logic        hit;

      always_comb begin
        hit        = chan.enable && ({1'b0, mag} >= thr[i]); // R3
        next_count = count;
        next_flag  = flag[i];
        if (hit) begin
          next_count = len_m1; // R6
          next_flag  = 1'b1; // R3
        end else if (count != `OD_RST_COUNT) begin
          next_count = count - `OD_COUNT_ONE; // R6
        end else begin
          next_flag  = 1'b0; // R3
        end
      end

      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          count   <= `OD_RST_COUNT;
          flag[i] <= 1'b0;
        end else begin
          count   <= next_count;
          flag[i] <= next_flag;
        end
      end
    end
  endgenerate
endmodule

// ### verilog/od_chan_if.sv
// per-channel link between register logic and one detector
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface od_chan_if;
  import od_pkg::*;
  od_sample_t sample;
  od_thr_t    upper_thr;
  od_thr_t    lower_thr;
  od_sel_t    stretch_sel;
  logic       enable;
  logic       upper_flag;
  logic       lower_flag;
  od_mag_t    magnitude;

  modport ctrl (
    output sample,
    output upper_thr,
    output lower_thr,
    output stretch_sel,
    output enable,
    input  upper_flag,
    input  lower_flag,
    input  magnitude
  );

  modport det (
    input  sample,
    input  upper_thr,
    input  lower_thr,
    input  stretch_sel,
    input  enable,
    output upper_flag,
    output lower_flag,
    output magnitude
  );
endinterface

// ### verilog/od_map.svh
// register offsets, field positions, reset values and counts of the overrange detector
// assumes inclusion by bare name from every design file that needs them
`ifndef OD_MAP_SVH
`define OD_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OD_ADR_CTRL     8'h00
`define OD_ADR_THRESH   8'h04
`define OD_ADR_STATUS   8'h08
`define OD_ADR_STICKY   8'h0c
`define OD_ADR_PEAK     8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OD_CTRL_EN_BIT   0
`define OD_CTRL_SEL_LSB  1
`define OD_CTRL_SEL_MSB  3
`define OD_THR_UP_LSB    0
`define OD_THR_UP_MSB    7
`define OD_THR_LO_LSB    8
`define OD_THR_LO_MSB    15
`define OD_FLAG_MSB      3
`define OD_PEAK_A_LSB    0
`define OD_PEAK_A_MSB    6
`define OD_PEAK_B_LSB    8
`define OD_PEAK_B_MSB    14
`define OD_SEL_PEAK_A    0
`define OD_SEL_PEAK_B    1
`define OD_SEL_BYTE0     0
`define OD_SEL_BYTE1     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OD_RST_EN        1'b0
`define OD_RST_SEL       3'h0
`define OD_RST_UPPER     8'h7f
`define OD_RST_LOWER     8'h40
`define OD_RST_FLAGS     4'h0
`define OD_RST_PEAK      7'h00
`define OD_RST_SAMPLE    8'h00
`define OD_RST_COUNT     11'h000
`define OD_RST_WORD      32'h0000_0000

// ----------------------------------------------------------------
// magnitude and stretch constants
// ----------------------------------------------------------------
`define OD_MOST_NEG      8'h80
`define OD_MAG_MAX       7'h7f
`define OD_STRETCH_BASE  11'h008
`define OD_COUNT_ONE     11'h001

`endif

// ### verilog/od_pkg.sv
// types shared by the overrange detector modules
// assumes nothing beyond a SystemVerilog compiler
package od_pkg;
  typedef logic [7:0]  od_sample_t;
  typedef logic [6:0]  od_mag_t;
  typedef logic [7:0]  od_thr_t;
  typedef logic [2:0]  od_sel_t;
  typedef logic [7:0]  od_adr_t;
  typedef logic [31:0] od_word_t;
  typedef logic [3:0]  od_be_t;
endpackage

// ### verilog/overrange_detector.sv
// overrange detector top: sample capture, two channel detectors, wishbone registers
// assumes samples come from converter logic on clock_i, two per cycle
// assumes a classic wishbone master on the same clock
//
// How it works
// R1 - sample maps to 7-bit magnitude; most negative code saturates to 127
// R2 - one upper and one lower threshold, shared by both channels
// R3 - flag goes high when magnitude reaches or exceeds its threshold
// R4 - two flags per channel; index 0 upper threshold, index 1 lower
// R5 - receiver ORs same-threshold flags of both channels in single-channel mode
// R6 - flag held 8 to 1024 cycles after last hit; hits restart count
// R7 - both core streams captured every clock edge as two sample lanes
// R8 - flags computed straight from converted samples with minimal latency
// R9 - software sets upper threshold near full scale to cut gain early
// R10 - downstream sets lower threshold low, raises gain while flag stays clear
// R11 - each core stream has its own compares and stretch counters
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "od_map.svh"
module overrange_detector (
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire od_pkg::od_sample_t sample_a_i,
  input  wire od_pkg::od_sample_t sample_b_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire od_pkg::od_adr_t  wb_adr_i,
  input  wire od_pkg::od_be_t   wb_sel_i,
  input  wire od_pkg::od_word_t wb_dat_i,
  output logic               wb_ack_o,
  output od_pkg::od_word_t   wb_dat_o,
  output logic               chan_a_upper_flag_o,
  output logic               chan_a_lower_flag_o,
  output logic               chan_b_upper_flag_o,
  output logic               chan_b_lower_flag_o
);
  import od_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic       enable;
  logic       next_enable;
  od_sel_t    stretch_sel;
  od_sel_t    next_stretch_sel;
  od_thr_t    upper_thr;
  od_thr_t    next_upper_thr;
  od_thr_t    lower_thr;
  od_thr_t    next_lower_thr;
  logic [3:0] sticky;
  logic [3:0] next_sticky;
  od_mag_t    peak      [2];
  od_mag_t    next_peak [2];
  od_sample_t cap       [2];
  od_sample_t next_cap  [2];
  logic       ack;
  logic       next_ack;
  od_word_t   rdata;
  od_word_t   next_rdata;
  logic       req;
  logic       wr;
  od_adr_t    word_adr;
  logic [3:0] flags;
  logic [3:0] sticky_clr;
  logic       peak_clr  [2];
  od_mag_t    mag       [2];
  od_sample_t sample_in [2];
  logic       wr_ctrl;
  logic       wr_thresh;
  logic       wr_sticky;
  logic       wr_peak;
  logic       rd;
  od_word_t   ctrl_word;
  od_word_t   thresh_word;
  od_word_t   status_word;
  od_word_t   sticky_word;
  od_word_t   peak_word;

  od_chan_if chan_if [2] ();

  // ----------------------------------------------------------------
  // sample capture
  // ----------------------------------------------------------------
  assign sample_in[0] = sample_a_i; // R7
  assign sample_in[1] = sample_b_i; // R7

  generate
    for (genvar c = 0; c < 2; c++) begin : g_cap
      always_comb begin
        next_cap[c] = sample_in[c]; // R7
      end

      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cap[c] <= `OD_RST_SAMPLE;
        end else begin
          cap[c] <= next_cap[c];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // channel detectors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      assign chan_if[g].sample      = cap[g]; // R8
      assign chan_if[g].upper_thr   = upper_thr; // R2
      assign chan_if[g].lower_thr   = lower_thr; // R2
      assign chan_if[g].stretch_sel = stretch_sel;
      assign chan_if[g].enable      = enable;
      assign mag[g]                 = chan_if[g].magnitude;

      od_chan_detect u_det ( // R11
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .chan     (chan_if[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag outputs
  // ----------------------------------------------------------------
  assign flags[0] = chan_if[0].upper_flag; // R4
  assign flags[1] = chan_if[0].lower_flag; // R4
  assign flags[2] = chan_if[1].upper_flag; // R4
  assign flags[3] = chan_if[1].lower_flag; // R4

  assign chan_a_upper_flag_o = flags[0];
  assign chan_a_lower_flag_o = flags[1];
  assign chan_b_upper_flag_o = flags[2];
  assign chan_b_lower_flag_o = flags[3];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign req      = wb_cyc_i && wb_stb_i && !ack;
  assign wr       = req && wb_we_i;
  assign rd       = req && !wb_we_i;
  assign word_adr = {wb_adr_i[7:2], 2'b00};

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  // a write lands at the taking edge; ack rises at that same edge
  assign wr_ctrl   = wr && (word_adr == `OD_ADR_CTRL);
  assign wr_thresh = wr && (word_adr == `OD_ADR_THRESH);
  assign wr_sticky = wr && (word_adr == `OD_ADR_STICKY);
  assign wr_peak   = wr && (word_adr == `OD_ADR_PEAK);

  always_comb begin
    sticky_clr  = `OD_RST_FLAGS;
    peak_clr[0] = 1'b0;
    peak_clr[1] = 1'b0;
    if (wr_sticky && wb_sel_i[`OD_SEL_BYTE0]) begin
      sticky_clr = wb_dat_i[`OD_FLAG_MSB:0];
    end
    if (wr_peak) begin
      peak_clr[0] = wb_sel_i[`OD_SEL_PEAK_A];
      peak_clr[1] = wb_sel_i[`OD_SEL_PEAK_B];
    end
  end

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word   = `OD_RST_WORD;
    thresh_word = `OD_RST_WORD;
    status_word = `OD_RST_WORD;
    sticky_word = `OD_RST_WORD;
    peak_word   = `OD_RST_WORD;
    ctrl_word[`OD_CTRL_EN_BIT]                   = enable;
    ctrl_word[`OD_CTRL_SEL_MSB:`OD_CTRL_SEL_LSB] = stretch_sel;
    thresh_word[`OD_THR_UP_MSB:`OD_THR_UP_LSB]   = upper_thr;
    thresh_word[`OD_THR_LO_MSB:`OD_THR_LO_LSB]   = lower_thr;
    status_word[`OD_FLAG_MSB:0]                  = flags;
    sticky_word[`OD_FLAG_MSB:0]                  = sticky;
    peak_word[`OD_PEAK_A_MSB:`OD_PEAK_A_LSB]     = peak[0];
    peak_word[`OD_PEAK_B_MSB:`OD_PEAK_B_LSB]     = peak[1];
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    next_ack   = req;
    next_rdata = `OD_RST_WORD;
    if (rd) begin
      unique case (word_adr)
        `OD_ADR_CTRL: begin
          next_rdata = ctrl_word;
        end
        `OD_ADR_THRESH: begin
          next_rdata = thresh_word;
        end
        `OD_ADR_STATUS: begin
          next_rdata = status_word;
        end
        `OD_ADR_STICKY: begin
          next_rdata = sticky_word;
        end
        `OD_ADR_PEAK: begin
          next_rdata = peak_word;
        end
        default: begin
          next_rdata = `OD_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack   <= 1'b0;
      rdata <= `OD_RST_WORD;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // ----------------------------------------------------------------
  // control and threshold registers
  // ----------------------------------------------------------------
  always_comb begin
    next_enable      = enable;
    next_stretch_sel = stretch_sel;
    next_upper_thr   = upper_thr;
    next_lower_thr   = lower_thr;
    // a new stretch length applies from the next hit
    if (wr_ctrl && wb_sel_i[`OD_SEL_BYTE0]) begin
      next_enable      = wb_dat_i[`OD_CTRL_EN_BIT];
      next_stretch_sel = wb_dat_i[`OD_CTRL_SEL_MSB:`OD_CTRL_SEL_LSB]; // R6
    end
    // thresholds above 127 never trip the 7-bit magnitude
    if (wr_thresh) begin
      if (wb_sel_i[`OD_SEL_BYTE0]) begin
        next_upper_thr = wb_dat_i[`OD_THR_UP_MSB:`OD_THR_UP_LSB]; // R2
      end
      if (wb_sel_i[`OD_SEL_BYTE1]) begin
        next_lower_thr = wb_dat_i[`OD_THR_LO_MSB:`OD_THR_LO_LSB]; // R2
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable      <= `OD_RST_EN;
      stretch_sel <= `OD_RST_SEL;
      upper_thr   <= `OD_RST_UPPER;
      lower_thr   <= `OD_RST_LOWER;
    end else begin
      enable      <= next_enable;
      stretch_sel <= next_stretch_sel;
      upper_thr   <= next_upper_thr;
      lower_thr   <= next_lower_thr;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    next_sticky = (sticky & ~sticky_clr) | flags;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sticky <= `OD_RST_FLAGS;
    end else begin
      sticky <= next_sticky;
    end
  end

  // ----------------------------------------------------------------
  // peak magnitude per channel
  // ----------------------------------------------------------------
  // a clear reloads the live magnitude, so a live sample wins
  generate
    for (genvar p = 0; p < 2; p++) begin : g_peak
      always_comb begin
        next_peak[p] = peak[p];
        if (peak_clr[p] || (mag[p] > peak[p])) begin
          next_peak[p] = mag[p];
        end
      end

      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          peak[p] <= `OD_RST_PEAK;
        end else begin
          peak[p] <= next_peak[p];
        end
      end
    end
  endgenerate
endmodule
